// file: logic/ipl_top.sv
// Interrupt pin drive, input sensing and hold timer with APB access
`timescale 1ns/1ps
module ipl_top #(
    parameter int HOLD_BASE_CYCLES = ipl_pkg::HOLD_BASE_CYC
) (
    input  wire logic        REF_CLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    input  wire logic [3:0]  PSTRB_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    input  wire logic        COND_A_IN,
    input  wire logic        COND_B_IN,
    input  wire logic        DIRECT_A_IN,
    input  wire logic        DIRECT_B_IN,
    input  wire logic        QUEUE_MARK_PIN_A_IN,
    input  wire logic        QUEUE_MARK_PIN_B_IN,
    input  wire logic        FIRST_IRQ_PIN_IN,
    output logic             FIRST_IRQ_PIN_OUT,
    output logic             FIRST_IRQ_PIN_OE_OUT,
    input  wire logic        SECOND_IRQ_PIN_IN,
    output logic             SECOND_IRQ_PIN_OUT,
    output logic             SECOND_IRQ_PIN_OE_OUT,
    output logic             POWER_TRIGGER_A_OUT,
    output logic             POWER_TRIGGER_B_OUT,
    output logic             QUEUE_TAG_A_OUT,
    output logic             QUEUE_TAG_B_OUT
);

    //==========================================================
    // State record
    localparam int CW = ipl_pkg::CNT_W;

    typedef struct packed {
        logic [7:0]          out_cfg;  // Pin drive setup
        logic [7:0]          hold_cfg; // Hold mode and input enables
        logic [1:0]          held;     // Held interrupt per pin
        logic [1:0][CW-1:0]  cnt;      // Timed hold countdown
        logic [1:0]          s1;       // Pin sync, first stage
        logic [1:0]          s2;       // Pin sync, second stage
        logic [1:0]          act_prv;  // Active level last cycle
        logic [1:0]          raw_prv;  // Raw level last cycle
        logic [1:0]          trig;     // Power trigger outputs
        logic [1:0]          tag;      // Queue tag pulses
        logic [1:0]          pin_out;  // Pin output level
        logic [1:0]          pin_oe;   // Pin output enable
        logic [31:0]         prdata;   // Read data
        logic                pready;   // Access phase answer
        logic                pslverr;  // Unmapped address
    } ipl_state_s;

    ipl_state_s r;       // Registered state
    ipl_state_s n;       // Next state
    logic [1:0] cond;    // Hold-mode interrupt conditions
    logic [1:0] direct;  // Conditions that bypass holding
    logic [1:0] qmark;   // Pin used for queue tagging
    logic [1:0] asserted;// Logical interrupt level per pin
    logic [1:0] drive;   // Driver enables
    logic [1:0] od;      // Open drain selects
    logic [1:0] pol;     // Polarity selects
    logic [1:0] edge_s;  // Edge sense selects
    logic [1:0] in_en;   // Input enables
    logic [3:0] mode;    // Hold mode code
    logic [1:0] act;     // Active input level after polarity
    logic [1:0] level;   // Line level wanted
    logic       wr;      // Write completes this edge
    logic       clr;     // Software latch clear
    logic [9:0] idx;     // Word index of the access
    logic       hit;     // Address maps to a register
    logic [CW-1:0] dur;  // Timed hold length in cycles

    //==========================================================
    // Decoding used by reads and writes alike
    function automatic logic mapped(input logic [9:0] a);
        mapped = (a == ipl_pkg::IDX_OUT_CFG) ||
                 (a == ipl_pkg::IDX_HOLD_CFG) ||
                 (a == ipl_pkg::IDX_CLEAR) ||
                 (a == ipl_pkg::IDX_STATUS);
    endfunction

    //==========================================================
    // Next-state logic
    // Reads only registered state and inputs, so every output
    // moves one edge after the registered state or input it reads directly
    always_comb begin
        n      = r;
        cond   = {COND_B_IN, COND_A_IN};
        direct = {DIRECT_B_IN, DIRECT_A_IN};
        qmark  = {QUEUE_MARK_PIN_B_IN, QUEUE_MARK_PIN_A_IN};
        drive  = {r.out_cfg[ipl_pkg::B_DRIVE], r.out_cfg[ipl_pkg::A_DRIVE]};
        od     = {r.out_cfg[ipl_pkg::B_OD], r.out_cfg[ipl_pkg::A_OD]};
        pol    = {r.out_cfg[ipl_pkg::B_POL], r.out_cfg[ipl_pkg::A_POL]};
        edge_s = {r.out_cfg[ipl_pkg::B_EDGE], r.out_cfg[ipl_pkg::A_EDGE]};
        in_en  = {r.hold_cfg[ipl_pkg::B_IN_EN],
                  r.hold_cfg[ipl_pkg::A_IN_EN]};
        mode   = r.hold_cfg[ipl_pkg::MODE_LSB +: 4];
        idx    = PADDR_IN[11:2];
        hit    = mapped(idx);
        wr     = PSEL_IN && PENABLE_IN && r.pready && PWRITE_IN &&
                 PSTRB_IN[0];
        clr    = wr && (idx == ipl_pkg::IDX_CLEAR) &&
                 PWDATA_IN[ipl_pkg::CLR_BIT];
        // Timed length doubles per code step above one
        dur    = CW'(HOLD_BASE_CYCLES) << (mode - 4'h1);
        act    = 2'b00;
        level  = 2'b00;
        asserted = 2'b00;

        // Register writes, at the completing access edge only
        // Clear and status keep nothing; a clear write only pulses clr
        if (wr && idx == ipl_pkg::IDX_OUT_CFG) begin
            n.out_cfg = PWDATA_IN[7:0];
        end else if (wr && idx == ipl_pkg::IDX_HOLD_CFG) begin
            n.hold_cfg = PWDATA_IN[7:0] & ipl_pkg::HOLD_WMASK;
        end

        // Ready one cycle after setup, so the access phase ends at once
        // Read data is staged at setup and stands through the access
        // An unmapped word answers with an error and reads zero
        n.pready  = PSEL_IN && !PENABLE_IN;
        n.pslverr = PSEL_IN && !PENABLE_IN && !hit;
        n.prdata  = 32'h0000_0000;
        if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
            if (idx == ipl_pkg::IDX_OUT_CFG) begin
                n.prdata[7:0] = r.out_cfg;
            end else if (idx == ipl_pkg::IDX_HOLD_CFG) begin
                n.prdata[7:0] = r.hold_cfg;
            end else if (idx == ipl_pkg::IDX_STATUS) begin
                n.prdata[7:0] = {2'b00, r.s2, r.pin_out, r.held};
            end
        end

        // Two stage synchroniser for the pin inputs
        // Only the second stage reads the first
        n.s1 = {SECOND_IRQ_PIN_IN, FIRST_IRQ_PIN_IN};
        n.s2 = r.s1;

        for (int k = 0; k < 2; k++) begin
            // Hold engine per pin
            // Timed hold counts from the last cycle the condition is seen
            // A clear also cancels a running timed hold
            if (mode == ipl_pkg::MODE_NONE) begin
                n.held[k] = cond[k];
                n.cnt[k]  = '0;
            end else if (mode == ipl_pkg::MODE_LATCH) begin
                // New condition beats a clear in the same cycle
                n.held[k] = cond[k] || (r.held[k] && !clr);
                n.cnt[k]  = '0;
            end else begin
                if (cond[k]) begin
                    n.cnt[k] = dur;
                end else if (clr) begin
                    n.cnt[k] = '0;
                end else if (r.cnt[k] != '0) begin
                    n.cnt[k] = r.cnt[k] - CW'(1);
                end
                n.held[k] = cond[k] || (n.cnt[k] != '0);
            end
            // Direct conditions skip the hold engine
            asserted[k] = r.held[k] || direct[k];

            // Output stage: polarity, then drive style
            // Open drain only pulls low; the far pull-up gives the high
            level[k] = pol[k] ? asserted[k] : !asserted[k];
            if (!drive[k]) begin
                n.pin_oe[k]  = 1'b0;
                n.pin_out[k] = 1'b0;
            end else if (od[k]) begin
                n.pin_oe[k]  = !level[k];
                n.pin_out[k] = 1'b0;
            end else begin
                n.pin_oe[k]  = 1'b1;
                n.pin_out[k] = level[k];
            end

            // Input path: polarity, then edge or level sensing
            // Edge sensing compares with last cycle's active level
            act[k]      = pol[k] ? r.s2[k] : !r.s2[k];
            n.act_prv[k] = act[k];
            n.raw_prv[k] = r.s2[k];
            if (!in_en[k]) begin
                n.trig[k] = 1'b0;
            end else if (edge_s[k]) begin
                n.trig[k] = act[k] && !r.act_prv[k];
            end else begin
                n.trig[k] = act[k];
            end
            // Tagging sees the raw rising edge, polarity unused
            n.tag[k] = in_en[k] && qmark[k] &&
                       r.s2[k] && !r.raw_prv[k];
        end
    end

    //==========================================================
    // State register
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            r          <= '0;
            r.out_cfg  <= ipl_pkg::OUT_CFG_RST;
            r.hold_cfg <= ipl_pkg::HOLD_CFG_RST;
            // Pins rest high at the pull-ups, so start there too:
            // no false raw edge once the input path is enabled
            r.s1       <= 2'h3;
            r.s2       <= 2'h3;
            r.raw_prv  <= 2'h3;
        end else begin
            r <= n;
        end
    end

    //==========================================================
    // Output wiring, all straight from flip-flops
    assign PRDATA_OUT            = r.prdata;
    assign PREADY_OUT            = r.pready;
    assign PSLVERR_OUT           = r.pslverr;
    assign FIRST_IRQ_PIN_OUT     = r.pin_out[0];
    assign FIRST_IRQ_PIN_OE_OUT  = r.pin_oe[0];
    assign SECOND_IRQ_PIN_OUT    = r.pin_out[1];
    assign SECOND_IRQ_PIN_OE_OUT = r.pin_oe[1];
    assign POWER_TRIGGER_A_OUT   = r.trig[0];
    assign POWER_TRIGGER_B_OUT   = r.trig[1];
    assign QUEUE_TAG_A_OUT       = r.tag[0];
    assign QUEUE_TAG_B_OUT       = r.tag[1];

    //==========================================================
    // Checks
    // Most look one edge after the setting; reset_clear_a and direct_pass_a check the same edge
    reset_clear_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        $rose(ARST_N_IN) |-> (r.out_cfg == 8'h00 && r.hold_cfg == 8'h00))
        else $error("Config not zero after reset");

    pin_b_off_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        !r.out_cfg[ipl_pkg::B_DRIVE] |=> !SECOND_IRQ_PIN_OE_OUT)
        else $error("Second pin driven while disabled");

    pin_b_pushpull_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::B_DRIVE] && !r.out_cfg[ipl_pkg::B_OD])
        |=> SECOND_IRQ_PIN_OE_OUT)
        else $error("Second pin push-pull not driving");

    pin_b_polarity_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::B_DRIVE] && !r.out_cfg[ipl_pkg::B_OD] &&
         r.out_cfg[ipl_pkg::B_POL])
        |=> (SECOND_IRQ_PIN_OUT == $past(asserted[1])))
        else $error("Second pin active-high level wrong");

    pin_a_off_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        !r.out_cfg[ipl_pkg::A_DRIVE] |=> !FIRST_IRQ_PIN_OE_OUT)
        else $error("First pin driven while disabled");

    pin_a_opendrain_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::A_DRIVE] && r.out_cfg[ipl_pkg::A_OD])
        |=> (!FIRST_IRQ_PIN_OUT &&
             FIRST_IRQ_PIN_OE_OUT == !$past(level[0])))
        else $error("First pin open drain wrong");

    pin_a_lowactive_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::A_DRIVE] && !r.out_cfg[ipl_pkg::A_OD] &&
         !r.out_cfg[ipl_pkg::A_POL])
        |=> (FIRST_IRQ_PIN_OUT == !$past(asserted[0])))
        else $error("First pin active-low level wrong");

    edge_single_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::A_EDGE] && $past(r.out_cfg[ipl_pkg::A_EDGE])
         && POWER_TRIGGER_A_OUT) |=> !POWER_TRIGGER_A_OUT)
        else $error("Edge trigger longer than one cycle");

    input_b_gate_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        !r.hold_cfg[ipl_pkg::B_IN_EN] |=> !POWER_TRIGGER_B_OUT)
        else $error("Second pin input not gated");

    input_a_gate_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        !r.hold_cfg[ipl_pkg::A_IN_EN] |=> !POWER_TRIGGER_A_OUT)
        else $error("First pin input not gated");

    follow_mode_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (mode == ipl_pkg::MODE_NONE) |=> (r.held[0] == $past(COND_A_IN)))
        else $error("Non-latched hold does not follow");

    timed_load_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (mode == 4'h2 && COND_A_IN)
        |=> (r.cnt[0] == CW'(2 * HOLD_BASE_CYCLES) && r.held[0]))
        else $error("Timed hold length wrong");

    timed_expire_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (mode != ipl_pkg::MODE_NONE && mode != ipl_pkg::MODE_LATCH &&
         r.cnt[0] == CW'(1) && !COND_A_IN) |=> !r.held[0])
        else $error("Timed hold outlasts its length");

    direct_pass_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        DIRECT_A_IN |-> asserted[0])
        else $error("Direct interrupt blocked");

    latch_keep_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (mode == ipl_pkg::MODE_LATCH && r.held[1] && !clr) |=> r.held[1])
        else $error("Latched interrupt dropped");

    pin_b_opendrain_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::B_DRIVE] && r.out_cfg[ipl_pkg::B_OD])
        |=> (!SECOND_IRQ_PIN_OUT &&
             SECOND_IRQ_PIN_OE_OUT == !$past(level[1])))
        else $error("Second pin open drain wrong");

    pin_b_lowactive_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::B_DRIVE] && !r.out_cfg[ipl_pkg::B_OD] &&
         !r.out_cfg[ipl_pkg::B_POL])
        |=> (SECOND_IRQ_PIN_OUT == !$past(asserted[1])))
        else $error("Second pin active-low level wrong");

    pin_a_pushpull_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::A_DRIVE] && !r.out_cfg[ipl_pkg::A_OD])
        |=> FIRST_IRQ_PIN_OE_OUT)
        else $error("First pin push-pull not driving");

    pin_a_highactive_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        (r.out_cfg[ipl_pkg::A_DRIVE] && !r.out_cfg[ipl_pkg::A_OD] &&
         r.out_cfg[ipl_pkg::A_POL])
        |=> (FIRST_IRQ_PIN_OUT == $past(asserted[0])))
        else $error("First pin active-high level wrong");

    tag_pulse_a: assert property (
        @(posedge REF_CLK_IN) disable iff (!ARST_N_IN)
        QUEUE_TAG_A_OUT |=> !QUEUE_TAG_A_OUT)
        else $error("Queue tag longer than one cycle");

endmodule

// file: shared/ipl_pkg.sv
// Constants for the interrupt pin configuration and hold logic
//==============================================================
// How it works
// - Both config registers clear to zero
// - Out bit 7 enables second pin driver
// - Out bit 6 picks open drain, pin two
// - Out bit 5 sets second pin polarity
// - Out bit 4 edge or level, pin two
// - Out bit 3 enables first pin driver
// - Out bit 2 picks open drain, pin one
// - Out bit 1 sets first pin polarity
// - Out bit 0 edge or level, pin one
// - Queue tagging ignores pin polarity
// - Hold bit 5 enables second pin input
// - Hold bit 4 enables first pin input
// - Hold low nibble: none, timed, latched
// - Timed hold doubles from 312.5 us
// - Direct interrupts bypass the hold mode
package ipl_pkg;
    //==========================================================
    // Register word indices; byte address is four times these
    localparam logic [9:0] IDX_OUT_CFG   = 10'h053; // Pin drive setup
    localparam logic [9:0] IDX_HOLD_CFG  = 10'h054; // Hold and input
    localparam logic [9:0] IDX_CLEAR     = 10'h060; // Latch clear
    localparam logic [9:0] IDX_STATUS    = 10'h061; // Live state
    // Reset values
    localparam logic [7:0] OUT_CFG_RST   = 8'h00;
    localparam logic [7:0] HOLD_CFG_RST  = 8'h00;
    // Field positions in the output configuration register
    localparam int B_DRIVE = 7;
    localparam int B_OD    = 6;
    localparam int B_POL   = 5;
    localparam int B_EDGE  = 4;
    localparam int A_DRIVE = 3;
    localparam int A_OD    = 2;
    localparam int A_POL   = 1;
    localparam int A_EDGE  = 0;
    // Field positions in the hold and input register
    localparam int B_IN_EN   = 5;
    localparam int A_IN_EN   = 4;
    localparam int MODE_LSB  = 0;
    localparam logic [7:0] HOLD_WMASK = 8'h3f; // Bits 7:6 reserved
    // Hold mode codes
    localparam logic [3:0] MODE_NONE  = 4'h0;
    localparam logic [3:0] MODE_LATCH = 4'hf;
    // Clear register bit
    localparam int CLR_BIT = 0;
    // Timing
    localparam real CLK_PERIOD_NS = 25.0;
    localparam real HOLD_BASE_US  = 312.5;  // Shortest timed hold
    localparam real HOLD_MAX_S    = 2.56;   // Longest timed hold
    localparam int  HOLD_BASE_CYC =
        $rtoi(HOLD_BASE_US * 1000.0 / CLK_PERIOD_NS);
    localparam int  CNT_W = 27;             // Fits 2.56 s at 40 MHz
endpackage

// file: tb/ipl_host_model.sv
// Host side of the two interrupt pins: pull-ups and trigger drivers
`timescale 1ns/1ps
module ipl_host_model (
    input  wire logic [1:0] dev_oe_in,  // Device drives pin
    input  wire logic [1:0] dev_lvl_in, // Device drive level
    input  wire logic [1:0] src_en_in,  // Host drives pin
    input  wire logic [1:0] src_lvl_in, // Host trigger level
    output logic      [1:0] wire_out    // Resolved pin levels
);
    //==========================================================
    // Pin resolution
    // Device wins while driving, then the host trigger; a pin neither side drives rests at the pull-up
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (dev_oe_in[i]) begin
                wire_out[i] = dev_lvl_in[i];
            end else if (src_en_in[i]) begin
                wire_out[i] = src_lvl_in[i];
            end else begin
                wire_out[i] = 1'b1;          // Pull-up level
            end
        end
    end
endmodule

// file: tb/tb_irq_pin_config_latch.sv
// Self-checking bench for pin drive, input sensing and hold timer
`timescale 1ns/1ps
module tb_irq_pin_config_latch;
    //==========================================================
    // Signals
    localparam int BASE = 4;      // Shortened timed hold unit
    logic        clk     = 1'b0;  // 40 MHz clock
    logic        arst_n  = 1'b0;  // Reset, active low
    logic        psel    = 1'b0;  // APB select
    logic        pen     = 1'b0;  // APB enable
    logic        pwr     = 1'b0;  // APB direction
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hf;  // Byte strobes
    logic [1:0]  cond    = 2'h0;  // Held conditions
    logic [1:0]  direct  = 2'h0;  // Bypass conditions
    logic [1:0]  qmark   = 2'h0;  // Queue tagging use
    logic [1:0]  src_en  = 2'h0;  // Host drives pin
    logic [1:0]  src_lvl = 2'h0;  // Host pin level
    logic [1:0]  oe;              // Design pin enables
    logic [1:0]  lvl;             // Design pin levels
    logic [1:0]  pin;             // Resolved pins
    logic [1:0]  trig;            // Power triggers
    logic [1:0]  tag;             // Queue tags
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] seed    = 32'hc187;
    int          bad_count = 0;
    int          tests_run = 0;
    always #12.5 clk = ~clk;
    //==========================================================
    // Design and host
    ipl_top #(.HOLD_BASE_CYCLES(BASE)) dut (
        .REF_CLK_IN           (clk),
        .ARST_N_IN            (arst_n),
        .PSEL_IN              (psel),
        .PENABLE_IN           (pen),
        .PWRITE_IN            (pwr),
        .PADDR_IN             (paddr),
        .PWDATA_IN            (pwdata),
        .PSTRB_IN             (pstrb),
        .PRDATA_OUT           (prdata),
        .PREADY_OUT           (pready),
        .PSLVERR_OUT          (pslverr),
        .COND_A_IN            (cond[0]),
        .COND_B_IN            (cond[1]),
        .DIRECT_A_IN          (direct[0]),
        .DIRECT_B_IN          (direct[1]),
        .QUEUE_MARK_PIN_A_IN  (qmark[0]),
        .QUEUE_MARK_PIN_B_IN  (qmark[1]),
        .FIRST_IRQ_PIN_IN     (pin[0]),
        .FIRST_IRQ_PIN_OUT    (lvl[0]),
        .FIRST_IRQ_PIN_OE_OUT (oe[0]),
        .SECOND_IRQ_PIN_IN    (pin[1]),
        .SECOND_IRQ_PIN_OUT   (lvl[1]),
        .SECOND_IRQ_PIN_OE_OUT(oe[1]),
        .POWER_TRIGGER_A_OUT  (trig[0]),
        .POWER_TRIGGER_B_OUT  (trig[1]),
        .QUEUE_TAG_A_OUT      (tag[0]),
        .QUEUE_TAG_B_OUT      (tag[1])
    );
    ipl_host_model host (
        .dev_oe_in (oe),
        .dev_lvl_in(lvl),
        .src_en_in (src_en),
        .src_lvl_in(src_lvl),
        .wire_out  (pin)
    );
    //==========================================================
    // Helpers
    // Xorshift step for repeatable random values
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Selects one watched output of pin p
    function automatic logic pick(input int s, input int p);
        case (s)
            0: return pin[p];
            1: return oe[p];
            2: return trig[p];
            default: return tag[p];
        endcase
    endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] x,
                       input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", w, x, g);
        end
    endtask
    // Count compare, inside lo..hi
    task automatic chk_n(input string w, input int lo, input int hi,
                         input int g);
        tests_run++;
        if (g < lo || g > hi) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                     w, lo, hi, g);
        end
    endtask
    // Counts cycles where a watched output equals v
    task automatic cnt(input int s, input int p, input logic v,
                       input int n, output int c);
        c = 0;
        repeat (n) begin
            @(posedge clk);
            if (pick(s, p) === v) begin
                c++;
            end
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        int k;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        r = {prdata[31:1], prdata[0] | (pslverr === 1'b1 && !w)};
        psel <= 1'b0;
        pen  <= 1'b0;
        if (k >= 20) begin
            bad_count++;
            complete_run();
        end
    endtask
    //==========================================================
    // Reset and scenarios
    initial begin
        logic [31:0] r;
        logic [7:0]  c;
        int          n;
        int          ln;
        int          ms[3];
        ms = '{1, 2, 14};
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        apb(0, 12'h14c, 0, r); chk("out cfg reset", 0, r);
        apb(0, 12'h150, 0, r); chk("hold reset", 0, r);
        apb(0, 12'h3fc, 0, r); chk("unmapped", 1, r);
        // Random register contents, with a strobe-less write
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            apb(1, 12'h14c, seed[7:0], r);
            apb(1, 12'h150, seed[15:8], r);
            pstrb <= 4'h0;
            apb(1, 12'h14c, ~seed[7:0], r);
            pstrb <= 4'hf;
            apb(0, 12'h14c, 0, r); chk("out cfg", seed[7:0], r);
            apb(0, 12'h150, 0, r); chk("hold", seed[13:8], r);
        end
        $display("test registers done");
        // Drive style and polarity table, non-latched
        apb(1, 12'h150, 8'h00, r);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 4; k++) begin
                c = {4'h0, 1'b1, k[1], k[0], 1'b0} << (4 * p);
                apb(1, 12'h14c, c, r);
                cond[p] <= 1'b1;
                cnt(0, p, k[0], 6, n); chk_n("asserted", 4, 5, n);
                cnt(1, p, 1, 4, n); chk_n("oe on", k == 3 ? 0 : 4, k == 3 ? 0 : 4, n);
                cond[p] <= 1'b0;
                cnt(0, p, !k[0], 6, n); chk_n("released", 4, 6, n);
                cnt(1, p, 1, 4, n); chk_n("oe off", k == 2 ? 0 : 4, k == 2 ? 0 : 4, n);
            end
            apb(1, 12'h14c, 8'h00, r);
            cond[p] <= 1'b1;
            @(posedge clk); // Let the old drive setting leave the pin
            cnt(1, p, 1, 8, n); chk_n("no drive", 0, 0, n);
            cond[p] <= 1'b0;
        end
        $display("test drive done");
        // Timed hold lengths, boundary code included
        apb(1, 12'h14c, 8'h0a, r);
        foreach (ms[i]) begin
            ln = BASE << (ms[i] - 1);
            apb(1, 12'h150, ms[i][7:0], r);
            cond[0] <= 1'b1;
            @(posedge clk);
            cond[0] <= 1'b0;
            cnt(0, 0, 1, 2 * ln + 8, n); chk_n("timed", ln, ln + 2, n);
        end
        $display("test timed done");
        // Latched hold, clear, and bypass conditions
        apb(1, 12'h150, 8'h0f, r);
        for (int p = 0; p < 2; p++) begin
            apb(1, 12'h14c, 8'h0a << (4 * p), r);
            cond[p] <= 1'b1;
            @(posedge clk);
            cond[p] <= 1'b0;
            cnt(0, p, 1, 20, n); chk_n("latched", 18, 20, n);
            apb(1, 12'h180, 8'h01, r);
            cnt(0, p, 1, 6, n); chk_n("cleared", 0, 1, n);
            apb(0, 12'h184, 0, r); chk("held flags", 0, r[1:0]);
            direct[p] <= 1'b1;
            cnt(0, p, 1, 6, n); chk_n("direct on", 4, 6, n);
            direct[p] <= 1'b0;
            cnt(0, p, 1, 10, n); chk_n("direct off", 0, 2, n);
        end
        $display("test latched done");
        // Input path: enable, edge or level, polarity, tagging
        apb(1, 12'h14c, 8'h00, r);
        qmark <= 2'h3;
        for (int p = 0; p < 2; p++) begin
            src_en[p] <= 1'b1;
            for (int k = 0; k < 4; k++) begin
                apb(1, 12'h14c, {6'h0, k[1], k[0]} << (4 * p), r);
                apb(1, 12'h150, 8'h10 << p, r);
                src_lvl[p] <= !k[1];
                cnt(2, p, 1, 8, n);
                src_lvl[p] <= k[1];
                cnt(2, p, 1, 12, n); chk_n("trigger", k[0] ? 1 : 8, k[0] ? 1 : 11, n);
                src_lvl[p] <= 1'b0;
                cnt(3, p, 1, 6, n);
                src_lvl[p] <= 1'b1;
                cnt(3, p, 1, 10, n); chk_n("tag", 1, 1, n);
                apb(1, 12'h150, 8'h00, r);
                src_lvl[p] <= 1'b0;
                cnt(2, p, 1, 6, n);
                src_lvl[p] <= 1'b1;
                cnt(2, p, 1, 10, n); chk_n("input off", 0, 0, n);
            end
            src_en[p] <= 1'b0;
        end
        $display("test input done");
        complete_run();
    end
endmodule
